/* include/win_pkg.sv */
// Package: constants and types for the shared RAM system bus window decoder
package win_pkg;
    // System address width (1 megabyte space)
    localparam int ADDR_W = 20;
    // Field positions inside the system address
    localparam int BLOCK_BIT = 19;
    localparam int SEG_HI = 18;
    localparam int SEG_LO = 16;
    localparam int PAGE_HI = 15;
    localparam int PAGE_LO = 12;
    localparam int SLOT_HI = 11;
    localparam int SLOT_LO = 10;
    localparam int OFS_HI = 9;
    // Delayed acknowledge least time and its cycle count at 50 MHz
    localparam int CLK_MHZ = 50;
    localparam int ACK_DELAY_NS = 1600;
    localparam int ACK_DELAY_CYC = (ACK_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 7;
    localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 7'h01;
    // Timeout length for an unanswered access, in cycles
    localparam logic [CNT_W-1:0] TMO_CYC = 7'h7f;

    // Window selection, held steady like board jumpers
    typedef struct packed {
        logic       enable;
        logic       block;
        logic [2:0] segment;
        logic [3:0] page;
        logic [1:0] slot;
    } win_cfg_t;

    // Acknowledge options
    typedef struct packed {
        logic tmo_enable;
        logic tmo_sys_too;
        logic delay_ack;
    } ack_cfg_t;

    // Sequencer states for one system bus access
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_DONE = 2'b10
    } acc_state_t;
endpackage : win_pkg

/* design/win_sync.sv */
// Two-flop synchroniser for a single level
`timescale 1ns/10ps
`default_nettype none
module win_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic d,
    output logic q
);
    logic meta_q; // First stage, read only by the second

    // Two stages to settle metastability
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : win_sync
`default_nettype wire

/* design/win_decoder.sv */
// Shared RAM window decoder and acknowledge sequencer on the system bus
`timescale 1ns/10ps
`default_nettype none
module win_decoder
    import win_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire win_cfg_t win_cfg,
    input wire ack_cfg_t ack_cfg,
    input wire logic [ADDR_W-1:0] sys_addr,
    input wire logic sys_rd_n,
    input wire logic sys_wr_n,
    input wire logic [7:0] sys_wdata,
    input wire logic [7:0] ram_rdata,
    input wire logic ram_ready,
    input wire logic local_tmo,
    output logic sys_ack_n,
    output logic sys_inhibit_n,
    output logic sys_tmo_ack,
    output logic local_tmo_ack,
    output logic [7:0] sys_rdata,
    output logic ram_req,
    output logic ram_we,
    output logic [OFS_HI:0] ram_addr,
    output logic [7:0] ram_wdata
);
    // Bus strobes are off-domain pins, so synchronise before use
    logic rd_s;
    logic wr_s;
    win_sync u_sync_rd (
        .clk(clk),
        .rst(rst),
        .d(~sys_rd_n),
        .q(rd_s)
    );
    win_sync u_sync_wr (
        .clk(clk),
        .rst(rst),
        .d(~sys_wr_n),
        .q(wr_s)
    );

    // Address and write data are pins too; they pass the same two
    // stages as the strobes, so they line up when the strobe is seen.
    // The master holds them steady around the strobe, so per-bit
    // capture cannot tear a value that the sequencer takes.
    logic [ADDR_W-1:0] addr_s; // Address after two stages
    logic [7:0] wdata_s; // Write data after two stages
    for (genvar i = 0; i < ADDR_W; i++) begin : g_addr_sync
        win_sync u_sync_addr (
            .clk(clk),
            .rst(rst),
            .d(sys_addr[i]),
            .q(addr_s[i])
        );
    end
    for (genvar j = 0; j < 8; j++) begin : g_wdata_sync
        win_sync u_sync_wdata (
            .clk(clk),
            .rst(rst),
            .d(sys_wdata[j]),
            .q(wdata_s[j])
        );
    end

    logic hit; // Address inside configured window
    logic cmd; // Any strobe active
    acc_state_t state_q; // Access sequencer
    acc_state_t state_d;
    logic [CNT_W-1:0] dly_q; // Delayed acknowledge countdown
    logic [CNT_W-1:0] tmo_q; // Timeout counter
    logic ram_seen_q; // RAM finished its part of the access
    logic is_wr_q; // Direction latched at start

    // Window compare on the synchronised address, field by field
    always_comb begin
        hit = win_cfg.enable
            && (addr_s[BLOCK_BIT] == win_cfg.block)
            && (addr_s[SEG_HI:SEG_LO] == win_cfg.segment)
            && (addr_s[PAGE_HI:PAGE_LO] == win_cfg.page)
            && (addr_s[SLOT_HI:SLOT_LO] == win_cfg.slot);
        cmd = rd_s | wr_s;
    end

    // Next state of the access sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (cmd && hit) begin
                    state_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                // Finish when RAM done and delay met, or on timeout
                if (!cmd) begin
                    state_d = ST_IDLE;
                end else if (ram_seen_q && dly_q == CNT_ZERO) begin
                    state_d = ST_DONE;
                end else if (tmo_q == CNT_ONE && ack_cfg.tmo_enable
                             && ack_cfg.tmo_sys_too) begin
                    state_d = ST_DONE;
                end
            end
            ST_DONE: begin
                // Hold the acknowledge until the master drops its strobe
                if (!cmd) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Sequencer state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Delay counter: loaded at access start, counts down to zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dly_q <= CNT_ZERO;
        end else if (state_q == ST_IDLE && state_d == ST_WAIT) begin
            // Zero when option off, so acknowledge follows RAM at once
            dly_q <= ack_cfg.delay_ack ? CNT_W'(ACK_DELAY_CYC) : CNT_ZERO;
        end else if (dly_q != CNT_ZERO) begin
            dly_q <= dly_q - CNT_ONE;
        end
    end

    // Timeout counter for a system access that RAM never finishes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tmo_q <= CNT_ZERO;
        end else if (state_q == ST_IDLE && state_d == ST_WAIT) begin
            tmo_q <= TMO_CYC;
        end else if (state_q == ST_WAIT && tmo_q != CNT_ZERO) begin
            tmo_q <= tmo_q - CNT_ONE;
        end
    end

    // RAM request and completion tracking
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ram_req <= 1'b0;
            ram_we <= 1'b0;
            ram_seen_q <= 1'b0;
            is_wr_q <= 1'b0;
        end else if (state_q == ST_IDLE && state_d == ST_WAIT) begin
            ram_req <= 1'b1;
            ram_we <= wr_s;
            is_wr_q <= wr_s;
            ram_seen_q <= 1'b0;
        end else if (state_q == ST_WAIT && ram_req && ram_ready) begin
            ram_req <= 1'b0;
            ram_we <= 1'b0;
            ram_seen_q <= 1'b1;
        end else if (state_q != ST_WAIT) begin
            ram_req <= 1'b0;
            ram_we <= 1'b0;
        end
    end

    // Address and data toward RAM; only the low ten bits, so the
    // local processor's own mapping is never disturbed
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ram_addr <= '0;
            ram_wdata <= 8'h00;
        end else if (state_q == ST_IDLE && state_d == ST_WAIT) begin
            ram_addr <= addr_s[OFS_HI:0];
            ram_wdata <= wdata_s;
        end
    end

    // Read data captured as RAM completes a read
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sys_rdata <= 8'h00;
        end else if (state_q == ST_WAIT && ram_req && ram_ready
                     && !is_wr_q) begin
            sys_rdata <= ram_rdata;
        end
    end

    // Acknowledge and timeout indication toward the system bus
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sys_ack_n <= 1'b1;
            sys_tmo_ack <= 1'b0;
        end else begin
            sys_ack_n <= !(state_d == ST_DONE);
            if (state_q == ST_WAIT && state_d == ST_DONE) begin
                sys_tmo_ack <= !(ram_seen_q && dly_q == CNT_ZERO);
            end else if (state_d == ST_IDLE) begin
                sys_tmo_ack <= 1'b0;
            end
        end
    end

    // Inhibit other memory whenever an active access hits the window;
    // comes from strobe and address so it leads the acknowledge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sys_inhibit_n <= 1'b1;
        end else begin
            sys_inhibit_n <= !(hit && cmd);
        end
    end

    // Local timeout acknowledge passes when globally enabled;
    // local_tmo is same-domain logic and needs no synchroniser
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            local_tmo_ack <= 1'b0;
        end else begin
            local_tmo_ack <= local_tmo && ack_cfg.tmo_enable;
        end
    end
endmodule : win_decoder
`default_nettype wire

/* bench/win_chk_assertions.sv */
// Port checker for the shared RAM window decoder
`timescale 1ns/10ps
`default_nettype none
module win_chk
    import win_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire win_cfg_t win_cfg,
    input wire ack_cfg_t ack_cfg,
    input wire logic [ADDR_W-1:0] sys_addr,
    input wire logic local_tmo,
    input wire logic sys_ack_n,
    input wire logic sys_inhibit_n,
    input wire logic local_tmo_ack,
    input wire logic ram_req,
    input wire logic [OFS_HI:0] ram_addr
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Address lies inside the configured 1K window
    wire logic hit = win_cfg.enable && sys_addr[19:10] ==
        {win_cfg.block, win_cfg.segment, win_cfg.page, win_cfg.slot};
    // Cycles since the RAM request began; saturates so aborts cannot wrap
    logic [7:0] wait_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wait_q <= 8'h00;
        end else if ($rose(ram_req)) begin
            wait_q <= 8'h01;
        end else if (wait_q != 8'hff) begin
            wait_q <= wait_q + 8'h01;
        end
    end
    a_req_window: assert property (ram_req |-> hit) else $error("req");
    a_ram_offset: assert property (
        ram_req |-> ram_addr == sys_addr[9:0]) else $error("offset");
    a_off_quiet: assert property (!win_cfg.enable |-> sys_ack_n)
        else $error("answer while off");
    a_inhibit_hit: assert property (!sys_inhibit_n |-> hit)
        else $error("inhibit outside window");
    a_ack_inhibit: assert property (!sys_ack_n |-> !sys_inhibit_n)
        else $error("ack without inhibit");
    a_ack_slow: assert property ($fell(sys_ack_n) && ack_cfg.delay_ack
        |-> wait_q >= 8'd79) else $error("delayed ack early");
    a_tmo_bound: assert property ($rose(ram_req) && ack_cfg.tmo_enable
        && ack_cfg.tmo_sys_too |-> ##[1:140] !sys_ack_n) else $error("tmo");
    a_local_tmo: assert property (!$past(rst) |-> local_tmo_ack ==
        ($past(local_tmo) && $past(ack_cfg.tmo_enable))) else $error("local");
    c_delay: cover property ($fell(sys_ack_n) && ack_cfg.delay_ack);
    c_inhibit: cover property ($fell(sys_inhibit_n));
    c_local: cover property (local_tmo_ack);
endmodule : win_chk
bind win_decoder win_chk chk (.clk, .rst, .win_cfg, .ack_cfg, .sys_addr,
    .local_tmo, .sys_ack_n, .sys_inhibit_n, .local_tmo_ack, .ram_req,
    .ram_addr);
`default_nettype wire

/* bench/ram_model.sv */
// Shared RAM on the far side, answering after a set latency
`timescale 1ns/10ps
`default_nettype none
module ram_model (
    input wire logic clk,
    input wire logic ram_req,
    input wire logic ram_we,
    input wire logic [9:0] ram_addr,
    input wire logic [7:0] ram_wdata,
    input wire logic [7:0] lat,
    output logic ram_ready,
    output logic [7:0] ram_rdata
);
    logic [7:0] mem [1024];
    logic [7:0] cnt = 8'h00;
    initial {ram_ready, ram_rdata} = 9'h000;
    // Waits lat cycles, 8'hff never answers; data churns when not valid
    always @(posedge clk) begin
        ram_ready <= 1'b0;
        ram_rdata <= ~ram_rdata;
        if (ram_req && !ram_ready && lat != 8'hff) begin
            cnt <= cnt + 8'h01;
            if (cnt >= lat) begin
                cnt <= 8'h00;
                ram_ready <= 1'b1;
                ram_rdata <= mem[ram_addr];
                if (ram_we) mem[ram_addr] <= ram_wdata;
            end
        end
    end
endmodule : ram_model
`default_nettype wire

/* bench/dual_port_ram_sysbus_window_test.sv */
// Bench for the shared RAM window decoder
`timescale 1ns/10ps
`default_nettype none
module dual_port_ram_sysbus_window_test;
    import win_pkg::*;
    logic clk, rst, sys_rd_n, sys_wr_n, local_tmo, ram_ready, ram_req;
    logic ram_we, sys_ack_n, sys_inhibit_n, sys_tmo_ack, local_tmo_ack;
    logic [7:0] sys_wdata, ram_rdata, sys_rdata, ram_wdata, lat;
    logic [9:0] ram_addr;
    logic [19:0] sys_addr;
    win_cfg_t win_cfg;
    ack_cfg_t ack_cfg;
    int num_errors = 0, tests_run = 0, cyc;
    // Window at block 1, segment 2, page 5, slot 3
    localparam logic [19:0] BASE = 20'ha5fff;
    win_decoder uut (.clk, .rst, .win_cfg, .ack_cfg, .sys_addr, .sys_rd_n,
        .sys_wr_n, .sys_wdata, .ram_rdata, .ram_ready, .local_tmo, .sys_ack_n,
        .sys_inhibit_n, .sys_tmo_ack, .local_tmo_ack, .sys_rdata, .ram_req,
        .ram_we, .ram_addr, .ram_wdata);
    ram_model ram (.clk, .ram_req, .ram_we, .ram_addr, .ram_wdata, .lat,
        .ram_ready, .ram_rdata);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic print_verdict();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic ok, input string s);
        tests_run++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("ERROR %0t %s", $time, s);
        end
    endtask : chk
    // One access; a hit answers unless the RAM stalls with no timeout
    task automatic acc(input logic wr, input logic [19:0] a, input int lim);
        logic tmo;
        logic exp;
        tmo = lat == 8'hff;
        exp = a[19:10] == BASE[19:10] && win_cfg.enable &&
            (!tmo || ack_cfg.tmo_enable && ack_cfg.tmo_sys_too);
        @(negedge clk);
        {sys_addr, sys_wdata} = {a, a[7:0]};
        {sys_rd_n, sys_wr_n} = {wr, !wr};
        for (cyc = 0; cyc < lim && sys_ack_n !== 1'b0; cyc++) @(negedge clk);
        chk((sys_ack_n === 1'b0) === exp, "ack");
        chk(sys_inhibit_n === !(exp || tmo), "inhibit");
        if (exp) chk(sys_tmo_ack === tmo && (wr || sys_rdata === a[7:0]), "rd");
        if (exp && cyc == lim) print_verdict();
        {sys_rd_n, sys_wr_n} = 2'b11;
        repeat (5) @(negedge clk);
        chk(sys_ack_n === 1'b1 && sys_inhibit_n === 1'b1, "release");
    endtask : acc
    // One bit off in each field misses; window off answers nothing
    task automatic t_decode();
        logic [19:0] m [5] = '{0, 20'h80000, 20'h10000, 20'h01000, 20'h00400};
        for (int i = 0; i < 5; i++) begin
            acc(1'b1, BASE ^ m[i], 40);
            acc(1'b0, BASE ^ m[i], 40);
        end
        win_cfg.enable = 1'b0;
        acc(1'b0, BASE, 40);
        win_cfg.enable = 1'b1;
        $display("decode done");
    endtask : t_decode
    task automatic t_delay();
        acc(1'b0, BASE, 40);
        chk(cyc < 80, "fast");
        ack_cfg.delay_ack = 1'b1;
        acc(1'b0, BASE, 300);
        chk(cyc >= 80, "slow");
        ack_cfg.delay_ack = 1'b0;
        $display("delay done");
    endtask : t_delay
    // Slow RAM, then a stalled RAM with both timeout bits set, then with each one alone
    task automatic t_tmo();
        lat = 8'h20;
        acc(1'b0, BASE, 300);
        lat = 8'hff;
        acc(1'b1, BASE - 20'h1, 300);
        ack_cfg = 3'b100;
        acc(1'b1, BASE - 20'h1, 200);
        ack_cfg = 3'b010;
        acc(1'b1, BASE - 20'h1, 200);
        {lat, ack_cfg} = {8'h00, 3'b110};
        $display("timeout done");
    endtask : t_tmo
    task automatic t_local();
        for (int i = 0; i < 2; i++) begin
            ack_cfg.tmo_enable = 1'(i);
            local_tmo = 1'b1;
            @(negedge clk);
            local_tmo = 1'b0;
            chk(local_tmo_ack === 1'(i), "local");
        end
        $display("local done");
    endtask : t_local
    initial begin
        {rst, sys_rd_n, sys_wr_n, local_tmo} = 4'b1110;
        {sys_addr, sys_wdata, lat, ack_cfg} = {36'h0, 3'b110};
        win_cfg = {1'b1, 1'b1, 3'h2, 4'h5, 2'h3};
        repeat (12) @(negedge clk);
        rst = 1'b0;
        chk(sys_ack_n === 1'b1 && sys_inhibit_n === 1'b1, "reset");
        t_decode();
        t_delay();
        t_tmo();
        t_local();
        print_verdict();
    end
endmodule : dual_port_ram_sysbus_window_test
`default_nettype wire
